// File: pwmio_pkg.sv
// Package with register map, field layout and constants for the PWM pin output stage
// Operation
// [R1] Ownership bits pick PWM (1) or GPIO (0) per pin; both reset to 1.
// [R2] Per-pin polarity bit: 1 makes the pin active-low, 0 active-high.
// [R3] Pair mode: 00 complementary, 10 push-pull, 01 third mode, 11 reserved.
// [R4] Software leaves pair mode alone while the global enable is set.
// [R5] Override enable makes high pin follow force bit 1, low pin bit 0.
// [R6] Active fault drives high pin to fault bit 1, low pin to bit 0.
// [R7] Active current limit drives pins to the limit value bits 1 and 0.
// [R8] With lock set, control writes are ignored unless unlock sequence preceded.
// [R9] Mode 01 is redundant: both pins carry the generator high waveform.
// [R10] Priority fault, then limit, then override, then generator; polarity last.
package pwmio_pkg;
    localparam logic [11:0] PWMIO_CTRL_ADDR     = 12'h000;
    localparam logic [11:0] PWMIO_UNLOCK_ADDR   = 12'h004;
    localparam logic [11:0] PWMIO_STATUS_ADDR   = 12'h008;
    localparam logic [15:0] PWMIO_CTRL_RESET    = 16'hC000;
    localparam logic [15:0] PWMIO_KEY_FIRST     = 16'h5A5A;
    localparam logic [15:0] PWMIO_KEY_SECOND    = 16'hA5A5;
    localparam int          PWMIO_HI_OWN_BIT    = 15;
    localparam int          PWMIO_LO_OWN_BIT    = 14;
    localparam int          PWMIO_HI_POL_BIT    = 13;
    localparam int          PWMIO_LO_POL_BIT    = 12;
    localparam int          PWMIO_MODE_HI_BIT   = 11;
    localparam int          PWMIO_MODE_LO_BIT   = 10;
    localparam int          PWMIO_HI_FEN_BIT    = 9;
    localparam int          PWMIO_LO_FEN_BIT    = 8;
    localparam int          PWMIO_FORCE_HI_BIT  = 7;
    localparam int          PWMIO_FORCE_LO_BIT  = 6;
    localparam int          PWMIO_FAULT_HI_BIT  = 5;
    localparam int          PWMIO_FAULT_LO_BIT  = 4;
    localparam int          PWMIO_LIMIT_HI_BIT  = 3;
    localparam int          PWMIO_LIMIT_LO_BIT  = 2;
    localparam logic [15:0] PWMIO_CTRL_MASK     = 16'hFFFC;
    localparam logic [1:0]  PWMIO_MODE_COMP     = 2'h0;
    localparam logic [1:0]  PWMIO_MODE_REDUND   = 2'h1;
    localparam logic [1:0]  PWMIO_MODE_PUSHPULL = 2'h2;
    localparam logic [1:0]  PWMIO_MODE_RSVD     = 2'h3;
    typedef enum logic [2:0] {
        PWMIO_LK_IDLE  = 3'b001,
        PWMIO_LK_KEY1  = 3'b010,
        PWMIO_LK_OPEN  = 3'b100
    } pwmio_lock_t;
endpackage : pwmio_pkg

// File: pwmio_top.sv
// Output pin stage of one PWM channel with APB control register
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module pwmio_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gen_high,
    input  wire logic        gen_low,
    input  wire logic        fault_active,
    input  wire logic        limit_active,
    input  wire logic        module_global_enable,
    input  wire logic        control_write_lock,
    input  wire logic        gpio_high,
    input  wire logic        gpio_low,
    output logic             high_side_pin,
    output logic             low_side_pin
);
    import pwmio_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl;
        pwmio_lock_t lk;
        logic [1:0]  flt_s;
        logic [1:0]  lim_s;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        hi;
        logic        lo;
    } pwmio_state_t;

    pwmio_state_t st_reg;
    pwmio_state_t st_next;
    logic         acc;
    logic         wr_ok;
    logic         f_hi;
    logic         f_lo;
    logic         w_hi;
    logic         w_lo;

    assign prdata  = st_reg.rdata;
    assign pready  = st_reg.ready;
    assign pslverr = st_reg.err;
    assign high_side_pin = st_reg.hi;
    assign low_side_pin  = st_reg.lo;
    // Single-cycle wait state: answer registered, pready in the access cycle's next edge
    assign acc = psel && penable && !st_reg.ready;

    always_comb begin
        st_next       = st_reg;
        st_next.ready = acc;
        st_next.err   = 1'b0;
        // Fault and limit come from pins, synchronised before use
        st_next.flt_s = {st_reg.flt_s[0], fault_active};
        st_next.lim_s = {st_reg.lim_s[0], limit_active};
        wr_ok = (!control_write_lock) || (st_reg.lk == PWMIO_LK_OPEN); // [R8]
        if (acc) begin
            st_next.rdata = 32'h0000_0000;
            if (pwrite) begin
                case (paddr)
                    PWMIO_CTRL_ADDR: begin
                        if (wr_ok) begin
                            st_next.ctrl = pwdata[15:0] & PWMIO_CTRL_MASK; // [R8]
                        end
                        // Each write consumes the unlock, even a dropped one
                        st_next.lk = PWMIO_LK_IDLE; // [R8]
                    end
                    PWMIO_UNLOCK_ADDR: begin
                        case (st_reg.lk)
                            PWMIO_LK_IDLE: begin
                                st_next.lk = (pwdata[15:0] == PWMIO_KEY_FIRST) ?
                                             PWMIO_LK_KEY1 : PWMIO_LK_IDLE;
                            end
                            PWMIO_LK_KEY1: begin
                                st_next.lk = (pwdata[15:0] == PWMIO_KEY_SECOND) ?
                                             PWMIO_LK_OPEN : PWMIO_LK_IDLE;
                            end
                            default: begin
                                st_next.lk = PWMIO_LK_IDLE;
                            end
                        endcase
                    end
                    default: begin
                        st_next.err = 1'b1;
                    end
                endcase
            end else begin
                case (paddr)
                    PWMIO_CTRL_ADDR: begin
                        st_next.rdata = {16'h0000, st_reg.ctrl};
                    end
                    PWMIO_UNLOCK_ADDR: begin
                        st_next.rdata = 32'h0000_0000;
                    end
                    PWMIO_STATUS_ADDR: begin
                        st_next.rdata = {28'h0000000, st_reg.lk == PWMIO_LK_OPEN,
                                         st_reg.lim_s[1], st_reg.flt_s[1],
                                         st_reg.ctrl[PWMIO_MODE_HI_BIT:PWMIO_MODE_LO_BIT]
                                         == PWMIO_MODE_RSVD};
                    end
                    default: begin
                        st_next.err = 1'b1;
                    end
                endcase
            end
        end
        // Generator waveforms by pair mode; reserved code parks both pins inactive
        case (st_reg.ctrl[PWMIO_MODE_HI_BIT:PWMIO_MODE_LO_BIT]) // [R3]
            PWMIO_MODE_COMP: begin
                w_hi = gen_high;
                w_lo = !gen_high;
            end
            PWMIO_MODE_REDUND: begin
                w_hi = gen_high; // [R9]
                w_lo = gen_high; // [R9]
            end
            PWMIO_MODE_PUSHPULL: begin
                w_hi = gen_high;
                w_lo = gen_low;
            end
            default: begin
                w_hi = 1'b0;
                w_lo = 1'b0;
            end
        endcase
        f_hi = w_hi;
        f_lo = w_lo;
        if (st_reg.flt_s[1]) begin
            f_hi = st_reg.ctrl[PWMIO_FAULT_HI_BIT]; // [R6] [R10]
            f_lo = st_reg.ctrl[PWMIO_FAULT_LO_BIT]; // [R6] [R10]
        end else if (st_reg.lim_s[1]) begin
            f_hi = st_reg.ctrl[PWMIO_LIMIT_HI_BIT]; // [R7] [R10]
            f_lo = st_reg.ctrl[PWMIO_LIMIT_LO_BIT]; // [R7] [R10]
        end else begin
            if (st_reg.ctrl[PWMIO_HI_FEN_BIT]) begin
                f_hi = st_reg.ctrl[PWMIO_FORCE_HI_BIT]; // [R5] [R10]
            end
            if (st_reg.ctrl[PWMIO_LO_FEN_BIT]) begin
                f_lo = st_reg.ctrl[PWMIO_FORCE_LO_BIT]; // [R5] [R10]
            end
        end
        // Polarity applied to the PWM value, after every forcing source and before the GPIO ownership select
        f_hi = f_hi ^ st_reg.ctrl[PWMIO_HI_POL_BIT]; // [R2] [R10]
        f_lo = f_lo ^ st_reg.ctrl[PWMIO_LO_POL_BIT]; // [R2] [R10]
        st_next.hi = st_reg.ctrl[PWMIO_HI_OWN_BIT] ? f_hi : gpio_high; // [R1]
        st_next.lo = st_reg.ctrl[PWMIO_LO_OWN_BIT] ? f_lo : gpio_low;  // [R1]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.ctrl  <= PWMIO_CTRL_RESET; // [R1]
            st_reg.lk    <= PWMIO_LK_IDLE;
            st_reg.flt_s <= 2'h0;
            st_reg.lim_s <= 2'h0;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.ready <= 1'b0;
            st_reg.err   <= 1'b0;
            st_reg.hi    <= 1'b0;
            st_reg.lo    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Mode field changes while enabled are unsupported; software must avoid them
    logic [1:0] mode_prev; // [R4]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev <= PWMIO_MODE_COMP;
        end else begin
            mode_prev <= st_reg.ctrl[PWMIO_MODE_HI_BIT:PWMIO_MODE_LO_BIT];
        end
    end

    sequence s_ctrl_write;
        psel && penable && !pready && pwrite && paddr == PWMIO_CTRL_ADDR;
    endsequence

    property p_locked_write_dropped;
        @(posedge pclk) disable iff (!presetn)
        (s_ctrl_write and control_write_lock && st_reg.lk != PWMIO_LK_OPEN)
        |=> $stable(st_reg.ctrl);
    endproperty
    a_locked_write_dropped: assert property (p_locked_write_dropped) // [R8]
        else $error("locked write changed control");

    property p_open_write_taken;
        @(posedge pclk) disable iff (!presetn)
        (s_ctrl_write and !control_write_lock)
        |=> st_reg.ctrl == ($past(pwdata[15:0]) & PWMIO_CTRL_MASK);
    endproperty
    a_open_write_taken: assert property (p_open_write_taken) // [R8]
        else $error("unlocked write not stored");

    property p_fault_drive;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.flt_s[1] && st_reg.ctrl[PWMIO_HI_OWN_BIT]) |=>
        high_side_pin == ($past(st_reg.ctrl[PWMIO_FAULT_HI_BIT])
                          ^ $past(st_reg.ctrl[PWMIO_HI_POL_BIT]));
    endproperty
    a_fault_drive: assert property (p_fault_drive) // [R6]
        else $error("fault value not on high pin");

    property p_limit_drive;
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.flt_s[1] && st_reg.lim_s[1] && st_reg.ctrl[PWMIO_LO_OWN_BIT]) |=>
        low_side_pin == ($past(st_reg.ctrl[PWMIO_LIMIT_LO_BIT])
                         ^ $past(st_reg.ctrl[PWMIO_LO_POL_BIT]));
    endproperty
    a_limit_drive: assert property (p_limit_drive) // [R7]
        else $error("limit value not on low pin");

    property p_override_drive;
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.flt_s[1] && !st_reg.lim_s[1] && st_reg.ctrl[PWMIO_HI_FEN_BIT]
         && st_reg.ctrl[PWMIO_HI_OWN_BIT]) |=>
        high_side_pin == ($past(st_reg.ctrl[PWMIO_FORCE_HI_BIT])
                          ^ $past(st_reg.ctrl[PWMIO_HI_POL_BIT]));
    endproperty
    a_override_drive: assert property (p_override_drive) // [R5]
        else $error("override value not on high pin");

    property p_gpio_owner;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.ctrl[PWMIO_LO_OWN_BIT] |=> low_side_pin == $past(gpio_low);
    endproperty
    a_gpio_owner: assert property (p_gpio_owner) // [R1]
        else $error("gpio not on low pin");

    property p_redundant;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.ctrl[15:8] == 8'hC4 && !st_reg.flt_s[1] && !st_reg.lim_s[1])
        |=> high_side_pin == low_side_pin;
    endproperty
    a_redundant: assert property (p_redundant) // [R9]
        else $error("redundant pins differ");

    property p_comp_polarity;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.ctrl[15:8] == 8'hE0 && !st_reg.flt_s[1] && !st_reg.lim_s[1])
        |=> high_side_pin == !$past(gen_high);
    endproperty
    a_comp_polarity: assert property (p_comp_polarity) // [R2]
        else $error("active-low high pin not inverted");

    property p_mode_stable_enabled;
        @(posedge pclk) disable iff (!presetn)
        module_global_enable |-> ##1 (st_reg.ctrl[PWMIO_MODE_HI_BIT:PWMIO_MODE_LO_BIT]
                                     == mode_prev || !$past(module_global_enable));
    endproperty
    a_mode_stable_enabled: assert property (p_mode_stable_enabled) // [R4]
        else $error("pair mode changed while enabled");

    property p_answer_one_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready;
    endproperty
    a_answer_one_wait: assert property (p_answer_one_wait)
        else $error("apb answer timing wrong");

    property p_fault_drive_low;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.flt_s[1] && st_reg.ctrl[PWMIO_LO_OWN_BIT]) |=>
        low_side_pin == ($past(st_reg.ctrl[PWMIO_FAULT_LO_BIT])
                         ^ $past(st_reg.ctrl[PWMIO_LO_POL_BIT]));
    endproperty
    a_fault_drive_low: assert property (p_fault_drive_low) // [R6]
        else $error("fault value not on low pin");

    property p_limit_drive_high;
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.flt_s[1] && st_reg.lim_s[1] && st_reg.ctrl[PWMIO_HI_OWN_BIT]) |=>
        high_side_pin == ($past(st_reg.ctrl[PWMIO_LIMIT_HI_BIT])
                          ^ $past(st_reg.ctrl[PWMIO_HI_POL_BIT]));
    endproperty
    a_limit_drive_high: assert property (p_limit_drive_high) // [R7]
        else $error("limit value not on high pin");

    property p_override_drive_low;
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.flt_s[1] && !st_reg.lim_s[1] && st_reg.ctrl[PWMIO_LO_FEN_BIT]
         && st_reg.ctrl[PWMIO_LO_OWN_BIT]) |=>
        low_side_pin == ($past(st_reg.ctrl[PWMIO_FORCE_LO_BIT])
                         ^ $past(st_reg.ctrl[PWMIO_LO_POL_BIT]));
    endproperty
    a_override_drive_low: assert property (p_override_drive_low) // [R5]
        else $error("override value not on low pin");

    property p_gpio_owner_high;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.ctrl[PWMIO_HI_OWN_BIT] |=> high_side_pin == $past(gpio_high);
    endproperty
    a_gpio_owner_high: assert property (p_gpio_owner_high) // [R1]
        else $error("gpio not on high pin");

    // Push-pull is the only mode where the low pin follows the low waveform
    property p_push_pull;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.ctrl[15:8] == 8'hC8 && !st_reg.flt_s[1] && !st_reg.lim_s[1])
        |=> {high_side_pin, low_side_pin} == {$past(gen_high), $past(gen_low)};
    endproperty
    a_push_pull: assert property (p_push_pull) // [R3]
        else $error("push-pull pins wrong");
endmodule : pwmio_top

// File: pwmio_switch_model.sv
// Behavioural model of the power switch pair on the output pins
`timescale 1ns/1ps
module pwmio_switch_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       high_side_pin,
    input  wire logic       low_side_pin,
    output logic      [1:0] switch_on
);
    // One clock late, standing in for gate driver delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_on <= 2'h0;
        end else begin
            switch_on <= {high_side_pin, low_side_pin};
        end
    end
endmodule : pwmio_switch_model

// File: pwmio_top_tb_top.sv
// Self-checking testbench for the PWM pin output stage
`timescale 1ns/1ps
module pwmio_top_tb_top;
    import pwmio_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, high_side_pin, low_side_pin;
    logic gen_high = 1'b0, gen_low = 1'b0, fault_active = 1'b0, limit_active = 1'b0;
    logic control_write_lock = 1'b0, gpio_high = 1'b0, gpio_low = 1'b0;
    logic module_global_enable = 1'b0;
    logic [1:0] sw;
    int fails = 0, n_checks = 0, cycles = 0;
    logic [1:0] mexp [4] = '{2'h2, 2'h3, 2'h3, 2'h0};

    pwmio_top u_pwmio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_high(gen_high), .gen_low(gen_low),
        .fault_active(fault_active), .limit_active(limit_active),
        .module_global_enable(module_global_enable),
        .control_write_lock(control_write_lock),
        .gpio_high(gpio_high), .gpio_low(gpio_low), .high_side_pin(high_side_pin),
        .low_side_pin(low_side_pin));
    pwmio_switch_model u_pwmio_switch_model (.pclk(pclk), .presetn(presetn),
        .high_side_pin(high_side_pin), .low_side_pin(low_side_pin), .switch_on(sw));

    initial begin
        forever #50 pclk = ~pclk;
    end

    task stop_test;
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Hang guard, well above the roughly 150 cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 2000) begin
            fails++;
            stop_test;
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
            fails++;
        end
    endtask : chk

    // Request held until pready is sampled high at a rising edge; data taken there
    task acc(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc

    // Fault and limit need three edges through the synchroniser
    // Ends on a rising edge so later stimulus stays edge aligned
    task pins(input logic [1:0] e);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk({30'h0, high_side_pin, low_side_pin}, {30'h0, e});
        chk({30'h0, sw}, {30'h0, e});
        @(posedge pclk);
    endtask : pins

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, PWMIO_CTRL_ADDR, 16'h0);
        chk(rd, {16'h0, PWMIO_CTRL_RESET});
        acc(1'b0, 12'h00C, 16'h0);
        chk({31'h0, er}, 32'h1);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'hFFFF);
        acc(1'b0, PWMIO_CTRL_ADDR, 16'h0);
        chk(rd, 32'h0000FFFC);
        gen_high <= 1'b1;
        gen_low <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            acc(1'b1, PWMIO_CTRL_ADDR, 16'hC000 | 16'(m << 10));
            pins(mexp[m]);
        end
        acc(1'b1, PWMIO_CTRL_ADDR, 16'hE000);
        // Mode stays complementary from here on, so enabling is safe
        module_global_enable <= 1'b1;
        pins(2'h0);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'hD000);
        pins(2'h3);
        gen_high <= 1'b0;
        gpio_high <= 1'b1;
        acc(1'b1, PWMIO_CTRL_ADDR, 16'h3000);
        pins(2'h2);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'hC380);
        pins(2'h2);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'hC318);
        pins(2'h0);
        limit_active <= 1'b1;
        pins(2'h2);
        fault_active <= 1'b1;
        pins(2'h1);
        acc(1'b0, PWMIO_STATUS_ADDR, 16'h0);
        chk(rd, 32'h00000006);
        limit_active <= 1'b0;
        fault_active <= 1'b0;
        control_write_lock <= 1'b1;
        acc(1'b1, PWMIO_CTRL_ADDR, 16'h0000);
        acc(1'b0, PWMIO_CTRL_ADDR, 16'h0);
        chk(rd, 32'h0000C318);
        acc(1'b1, PWMIO_UNLOCK_ADDR, PWMIO_KEY_FIRST);
        acc(1'b1, PWMIO_UNLOCK_ADDR, PWMIO_KEY_SECOND);
        acc(1'b0, PWMIO_STATUS_ADDR, 16'h0);
        chk(rd, 32'h00000008);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'h4000);
        acc(1'b0, PWMIO_CTRL_ADDR, 16'h0);
        chk(rd, 32'h00004000);
        acc(1'b1, PWMIO_CTRL_ADDR, 16'h8000);
        acc(1'b0, PWMIO_CTRL_ADDR, 16'h0);
        chk(rd, 32'h00004000);
        stop_test;
    end
endmodule : pwmio_top_tb_top
